// [rsss_partner_model.sv]
// Purpose: Processor and oscillator model facing the sequencer
// Assumes: Runs on the system clock; sequencer resyncs both outputs
// Notes: Code walks one step per interval unless a direct load is asked
module rsss_partner_model
  import rsss_pkg::*;
#(
  parameter int OSC_HALF = 4, // Half period of soft-start oscillator
  parameter int T_STEP = 16 // Cycles between code steps
) (
  input wire logic clk, // System clock
  input wire logic [CODE_W-1:0] want, // Code the processor aims for
  input wire logic load, // Put the wanted code out at once
  output logic osc, // Soft-start oscillator
  output logic [CODE_W-1:0] code // Voltage-select code
);
  timeunit 1ns;
  timeprecision 1ps;
  int osc_cnt = 0;
  int vid_cnt = 0;
  logic osc_q = 1'b0;
  logic [CODE_W-1:0] code_q = 8'h00;
  // One driver each for the outputs
  assign osc = osc_q;
  assign code = code_q;
  // Oscillator runs free; one reference step per period
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1) begin
      osc_q <= ~osc_q;
    end
  end
  // One code per interval, like the real processor, or the wanted code at once on load
  always @(posedge clk) begin
    vid_cnt <= (vid_cnt == T_STEP - 1) ? 0 : vid_cnt + 1;
    if (load) begin
      code_q <= want;
    end else if (vid_cnt == T_STEP - 1 && code_q < want) begin
      code_q <= code_q + 8'h01;
    end else if (vid_cnt == T_STEP - 1 && code_q > want) begin
      code_q <= code_q - 8'h01;
    end
  end
endmodule // rsss_partner_model

// [rsss_pkg.sv]
// Purpose: Shared constants and types for the regulator soft-start sequencer
// Assumes: 200 MHz system clock, 8-bit voltage-select code, 6.25mV per code
// Notes: Times are held in ns and converted to cycles
package rsss_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CODE_W = 8;
  // Delays in ns as documented
  localparam int FIRST_DELAY_NS = 1360000;
  localparam int HOLD_NS = 85000;
  localparam int VALIDATE_NS = 500;
  localparam int READY_DELAY_NS = 85000;
  // Cycle counts, rounded up for least times
  localparam int FIRST_DELAY_CYC =
    (FIRST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VALIDATE_CYC =
    (VALIDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_DELAY_CYC =
    (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 19;
  // Boot level 1.1V as reference code (1100mV / 6.25mV = 176)
  localparam logic [CODE_W-1:0] BOOT_CODE = 8'hB0;
  localparam logic [CODE_W-1:0] ZERO_CODE = 8'h00;
  // Two OFF codes of the selection table
  localparam logic [CODE_W-1:0] OFF_CODE_A = 8'hFE;
  localparam logic [CODE_W-1:0] OFF_CODE_B = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 19'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 19'h00001;

  typedef enum logic [2:0] {
    ST_SHUTDOWN, ST_FIRST_DELAY, ST_RAMP_BOOT, ST_HOLD, ST_RAMP_TARGET,
    ST_READY_WAIT, ST_RUN, ST_OFF_LATCH
  } rsss_state_type;
endpackage : rsss_pkg

// [rsss_ramp_if.sv]
// Purpose: Carries ramp request and reference between sequencer parts
// Assumes: Single clock domain
// Notes: Controller drives request and target, stepper returns the code
interface rsss_ramp_if;
  import rsss_pkg::*;
  logic run;
  logic clear;
  logic [CODE_W-1:0] target;
  logic [CODE_W-1:0] ref_code;
  logic at_target;
  modport ctrl (output run, output clear, output target,
                input ref_code, input at_target);
  modport step (input run, input clear, input target,
                output ref_code, output at_target);
endinterface : rsss_ramp_if

// [rsss_ramp_stepper.sv]
// Purpose: Steps the reference code one code per oscillator tick
// Assumes: Tick is a one-cycle pulse already synchronised
// Notes: Moves in either direction so code changes are followed on the fly
module rsss_ramp_stepper
  import rsss_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic tick, // Oscillator tick pulse
  rsss_ramp_if.step rp // Ramp control
);
  logic [CODE_W-1:0] ref_code;
  logic [CODE_W-1:0] next_ref_code;

  // ----------------------------------------
  // Step logic
  // ----------------------------------------
  // Compare with target on each tick, one code per step
  always_comb begin
    next_ref_code = ref_code;
    if (rp.clear) begin
      next_ref_code = ZERO_CODE;
    end else if (rp.run && tick) begin
      if (ref_code < rp.target) begin
        next_ref_code = ref_code + 8'h01;
      end else if (ref_code > rp.target) begin
        next_ref_code = ref_code - 8'h01;
      end
    end
  end

  // Register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_code <= ZERO_CODE;
    end else begin
      ref_code <= next_ref_code;
    end
  end

  assign rp.ref_code = ref_code;
  assign rp.at_target = (ref_code == rp.target);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_step_one_code: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(rp.clear) |-> (ref_code - $past(ref_code) == 8'h00 ||
    ref_code - $past(ref_code) == 8'h01 ||
    $past(ref_code) - ref_code == 8'h01))
    else $error("reference moved by more than one code");
  a_step_on_tick: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!tick && !rp.clear) |=> $stable(ref_code))
    else $error("reference moved without a tick");
endmodule // rsss_ramp_stepper

// [rsss_sequencer.sv]
// Purpose: Soft-start and ready sequencer for a core regulator controller
// Assumes: Comparator and fault levels arrive from analog, asynchronously
// Notes: Soft-start oscillator is sampled and edge detected on CLK_SYS
module rsss_sequencer
  import rsss_pkg::*;
#(
  parameter int FIRST_DELAY = FIRST_DELAY_CYC, // Cycles of first delay
  parameter int HOLD = HOLD_CYC, // Cycles of boot hold
  parameter int READY_DELAY = READY_DELAY_CYC // Cycles before ready
) (
  input wire logic CLK_SYS, // 200 MHz clock
  input wire logic RST_N, // Async reset, active low
  input wire logic BIAS_POR_OK, // Bias above reset threshold
  input wire logic PRIMARY_ENABLE_IN, // Primary enable comparator
  input wire logic TERMINATION_RAIL_ENABLE_IN, // Termination comparator
  input wire logic SOFTSTART_OSC, // Resistor-set oscillator
  input wire logic [CODE_W-1:0] VOLTAGE_SELECT_CODE, // Processor code
  input wire logic [CODE_W-1:0] OFFSET_CODES, // Offset in code steps
  input wire logic UNDERVOLT, // Undervoltage detected
  input wire logic OVERVOLT, // Overvoltage detected
  output logic PWM_OE, // PWM drive enable, low keeps outputs tri-stated
  output logic [CODE_W-1:0] REF_CODE, // Reference code to the DAC
  output logic REGULATOR_READY_OUT, // Ready pin output level (low)
  output logic REGULATOR_READY_OE // Ready pin pull-down enable
);
  logic [1:0] rst_sync;
  logic rst_n;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // Input synchronisers, three stages
  // ----------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1, s2, s3, filt;
  logic [NSYNC-1:0] next_filt;
  logic [CODE_W-1:0] code1, code2, code3, code_f, next_code_f;
  assign raw_in = {OVERVOLT, UNDERVOLT, SOFTSTART_OSC,
                   TERMINATION_RAIL_ENABLE_IN, PRIMARY_ENABLE_IN, BIAS_POR_OK};

  // Accept a change once stages two and three agree
  always_comb begin
    next_code_f = (code2 == code3) ? code3 : code_f;
    next_filt = filt;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2[i] == s3[i]) begin
        next_filt[i] = s3[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
      code1 <= ZERO_CODE;
      code2 <= ZERO_CODE;
      code3 <= ZERO_CODE;
      code_f <= ZERO_CODE;
    end else begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      code1 <= VOLTAGE_SELECT_CODE;
      code2 <= code1;
      code3 <= code2;
      code_f <= next_code_f;
    end
  end

  logic por_ok, en_pri, en_term, osc, uv, ov, osc_d, tick, start_ok;
  assign {ov, uv, osc, en_term, en_pri, por_ok} = filt;
  assign tick = osc && !osc_d;
  // All three start conditions together
  assign start_ok = por_ok && en_pri && en_term;

  function automatic logic is_off(input logic [CODE_W-1:0] c);
    return (c == OFF_CODE_A) || (c == OFF_CODE_B);
  endfunction

  // ----------------------------------------
  // Ramp stepper
  // ----------------------------------------
  rsss_ramp_if rp ();
  rsss_ramp_stepper u_step (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .tick(tick),
    .rp(rp.step)
  );

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  rsss_state_type state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, vcnt, next_vcnt;
  logic [CODE_W-1:0] target, next_target;
  logic pwm_oe, next_pwm_oe, rdy_oe, next_rdy_oe;

  // Final target is selected code less offset, floored at zero
  function automatic logic [CODE_W-1:0] final_target(
    input logic [CODE_W-1:0] c, input logic [CODE_W-1:0] o);
    return (c > o) ? c - o : ZERO_CODE;
  endfunction

  always_comb begin
    next_state = state;
    next_cnt = (cnt != CNT_ZERO) ? cnt - CNT_ONE : CNT_ZERO;
    // Code must be stable and valid for the validation time
    next_vcnt = vcnt;
    if (code_f != code3 || is_off(code_f)) begin
      next_vcnt = CNT_ZERO;
    end else if (vcnt < CNT_W'(VALIDATE_CYC)) begin
      next_vcnt = vcnt + CNT_ONE;
    end
    next_target = target;
    if (!start_ok) begin
      // Disable or bias loss returns to shutdown, also clears OFF latch
      next_state = ST_SHUTDOWN;
      next_target = ZERO_CODE;
    end else begin
      unique case (state)
        ST_SHUTDOWN: begin
          next_state = ST_FIRST_DELAY;
          next_cnt = CNT_W'(FIRST_DELAY);
        end
        ST_FIRST_DELAY: if (cnt == CNT_ONE) begin
          next_state = ST_RAMP_BOOT;
          next_target = BOOT_CODE;
        end
        ST_RAMP_BOOT: if (rp.at_target) begin
          next_state = ST_HOLD;
          next_cnt = CNT_W'(HOLD);
        end
        ST_HOLD: begin
          if (cnt <= CNT_ONE && is_off(code_f)) begin
            next_state = ST_OFF_LATCH;
            next_target = ZERO_CODE;
          end else if (cnt <= CNT_ONE &&
                       vcnt >= CNT_W'(VALIDATE_CYC)) begin
            next_state = ST_RAMP_TARGET;
            next_target = final_target(code_f, OFFSET_CODES);
          end
        end
        ST_RAMP_TARGET: if (rp.at_target) begin
          next_state = ST_READY_WAIT;
          next_cnt = CNT_W'(READY_DELAY);
        end
        ST_READY_WAIT, ST_RUN: begin
          // Follow on-the-fly code changes from the processor
          if (is_off(code_f)) begin
            next_state = ST_OFF_LATCH;
            next_target = ZERO_CODE;
          end else begin
            next_target = final_target(code_f, OFFSET_CODES);
            if (state == ST_READY_WAIT && cnt == CNT_ONE) begin
              next_state = ST_RUN;
            end
          end
        end
        ST_OFF_LATCH: next_state = ST_OFF_LATCH; // Needs input cycling
      endcase
    end
    // PWM only driven outside shutdown and the OFF latch
    next_pwm_oe = !(next_state == ST_SHUTDOWN ||
                    next_state == ST_OFF_LATCH);
    // Ready pulled low unless running and free of faults
    next_rdy_oe = !(next_state == ST_RUN) || uv || ov;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SHUTDOWN;
      cnt <= CNT_ZERO;
      vcnt <= CNT_ZERO;
      target <= ZERO_CODE;
      pwm_oe <= 1'b0;
      rdy_oe <= 1'b1;
      osc_d <= 1'b0;
      REF_CODE <= ZERO_CODE;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      vcnt <= next_vcnt;
      target <= next_target;
      pwm_oe <= next_pwm_oe;
      rdy_oe <= next_rdy_oe;
      osc_d <= osc;
      REF_CODE <= rp.ref_code;
    end
  end

  // Ramp restarts from zero in shutdown
  assign rp.run = (state != ST_SHUTDOWN) && (state != ST_FIRST_DELAY);
  assign rp.clear = (state == ST_SHUTDOWN) || (state == ST_OFF_LATCH);
  assign rp.target = target;
  assign PWM_OE = pwm_oe;
  assign REGULATOR_READY_OE = rdy_oe;
  assign REGULATOR_READY_OUT = 1'b0; // Open drain: only pulls low

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_ready_rise;
    !rdy_oe ##0 $past(rdy_oe);
  endsequence
  a_pwm_off_shut: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == ST_SHUTDOWN |-> !pwm_oe)
    else $error("PWM enabled in shutdown");
  a_start_needs_all: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    !start_ok |=> state == ST_SHUTDOWN)
    else $error("left shutdown without start conditions");
  a_enable_drop: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (!en_pri || !en_term) |=> rdy_oe)
    else $error("ready not low after enable loss");
  a_first_delay: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    $rose(state == ST_FIRST_DELAY) |-> rp.ref_code == ZERO_CODE)
    else $error("reference not zero at delay start");
  a_boot_target: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == ST_HOLD |-> rp.ref_code == BOOT_CODE)
    else $error("hold not at boot level");
  a_off_latch: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (state == ST_OFF_LATCH && start_ok) |=> state == ST_OFF_LATCH)
    else $error("off latch released without input cycling");
  a_ready_fault: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (uv || ov) |=> rdy_oe)
    else $error("ready released during fault");
  // Release only from run, or at the last count of the ready delay
  a_ready_after: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    s_ready_rise |-> $past(state) == ST_RUN ||
    ($past(state) == ST_READY_WAIT && $past(cnt) == CNT_ONE))
    else $error("ready released outside run");
  a_ready_shut: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    state == ST_SHUTDOWN |-> rdy_oe)
    else $error("ready released in shutdown");
endmodule // rsss_sequencer

// [tb_top.sv]
// Purpose: Self-checking bench for the soft-start sequencer
// Assumes: Shortened delays; oscillator period of 8 clock cycles
// Notes: Inputs change at the falling edge; waits are bounded
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top
  import rsss_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FD = 50;
  localparam int HD = 20;
  localparam int RD = 20;
  localparam int OP = 8;
  logic clk = 1'b0, rst_n = 1'b0, bias = 1'b0, pen = 1'b0, ten = 1'b0;
  logic uv = 1'b0, ov = 1'b0, load = 1'b0;
  logic [7:0] offs = 8'h04, want = 8'h00, prev_ref = 8'h00;
  logic pwm_oe, rdy_out, rdy_oe, osc;
  logic [7:0] ref_code, code;
  int n_errors = 0, total_checks = 0, since = 0;
  bit step_mon = 1'b0;
  bit one_step = 1'b0;
  // ----------------------------------------
  // Clock, parts
  // ----------------------------------------
  always #2.5 clk = ~clk;
  rsss_sequencer #(.FIRST_DELAY(FD), .HOLD(HD), .READY_DELAY(RD))
    i_rsss_sequencer (.CLK_SYS(clk), .RST_N(rst_n), .BIAS_POR_OK(bias),
    .PRIMARY_ENABLE_IN(pen), .TERMINATION_RAIL_ENABLE_IN(ten),
    .SOFTSTART_OSC(osc), .VOLTAGE_SELECT_CODE(code), .OFFSET_CODES(offs),
    .UNDERVOLT(uv), .OVERVOLT(ov), .PWM_OE(pwm_oe), .REF_CODE(ref_code),
    .REGULATOR_READY_OUT(rdy_out), .REGULATOR_READY_OE(rdy_oe));
  rsss_partner_model #(.OSC_HALF(OP / 2), .T_STEP(16)) i_rsss_partner_model
    (.clk(clk), .want(want), .load(load), .osc(osc), .code(code));
  // Ramps move one code, no faster than the oscillator
  always @(negedge clk) begin
    if (step_mon && ref_code !== prev_ref) begin
      one_step = (ref_code - prev_ref == 8'h01) ||
                 (prev_ref - ref_code == 8'h01);
      `CHK(one_step, 1'b1)
      `CHK(since >= OP - 2, 1'b1)
      since = 0;
    end else since = since + 1;
    prev_ref = ref_code;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wait_ref(input logic [7:0] v, output int n);
    n = 0;
    while (ref_code !== v && n < 4000) begin
      @(negedge clk);
      n++;
    end
    // A wait that runs out shows up as a mismatch here
    `CHK(ref_code, v)
  endtask
  task automatic set_code(input logic [7:0] v);
    want = v;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
  endtask
  task automatic all_en(input logic v);
    bias = v;
    @(negedge clk);
    pen = v;
    ten = v;
  endtask
  // Missing start condition keeps everything parked
  task automatic t_gate;
    for (int i = 0; i < 3; i++) begin
      bias = (i != 0);
      pen = (i != 1);
      ten = (i != 2);
      repeat (FD + 40) @(negedge clk);
      `CHK(pwm_oe, 1'b0)
      `CHK(ref_code, 8'h00)
      `CHK(rdy_oe, 1'b1)
    end
  endtask
  // Full soft-start with the code valid well before boot level
  task automatic t_start(input logic [7:0] v);
    int n;
    all_en(1'b0);
    step_mon = 1'b0;
    repeat (8) @(negedge clk);
    set_code(v);
    all_en(1'b1);
    step_mon = 1'b1;
    wait_ref(8'h01, n);
    `CHK(n >= FD, 1'b1)
    wait_ref(BOOT_CODE, n);
    `CHK(ref_code, BOOT_CODE)
    n = 0;
    while (ref_code === BOOT_CODE && n < 4000) begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= HD, 1'b1)
    `CHK(n < 4000, 1'b1)
    wait_ref(v - offs, n);
    `CHK(ref_code, v - offs)
    repeat (RD - 4) @(negedge clk);
    `CHK(rdy_oe, 1'b1)
    repeat (12) @(negedge clk);
    `CHK(rdy_oe, 1'b0)
    `CHK(rdy_out, 1'b0)
  endtask
  // Code walks up two and back; reference follows
  task automatic t_track;
    int n;
    want = 8'hCA;
    wait_ref(8'hC6, n);
    `CHK(ref_code, 8'hC6)
    want = 8'hC8;
    wait_ref(8'hC4, n);
    `CHK(ref_code, 8'hC4)
  endtask
  // Each fault pulls ready while PWM keeps running
  task automatic t_faults;
    for (int i = 0; i < 2; i++) begin
      uv = (i == 0);
      ov = (i == 1);
      repeat (8) @(negedge clk);
      `CHK(rdy_oe, 1'b1)
      `CHK(pwm_oe, 1'b1)
      uv = 1'b0;
      ov = 1'b0;
      repeat (8) @(negedge clk);
      `CHK(rdy_oe, 1'b0)
    end
  endtask
  // Losing the termination enable shuts down
  task automatic t_disable;
    step_mon = 1'b0;
    ten = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(pwm_oe, 1'b0)
    `CHK(rdy_oe, 1'b1)
    `CHK(ref_code, 8'h00)
  endtask
  // OFF code read at hold end latches shutdown until an enable cycles
  task automatic t_off_hold;
    int n;
    all_en(1'b0);
    repeat (8) @(negedge clk);
    set_code(OFF_CODE_A);
    all_en(1'b1);
    wait_ref(BOOT_CODE, n);
    repeat (HD + 200) @(negedge clk);
    `CHK(pwm_oe, 1'b0)
    set_code(8'hC0);
    repeat (200) @(negedge clk);
    `CHK(pwm_oe, 1'b0)
    `CHK(rdy_oe, 1'b1)
    pen = 1'b0;
    repeat (8) @(negedge clk);
    pen = 1'b1;
    repeat (20) @(negedge clk);
    `CHK(pwm_oe, 1'b1)
  endtask
  // OFF code while running
  task automatic t_off_run;
    step_mon = 1'b0;
    set_code(OFF_CODE_B);
    repeat (20) @(negedge clk);
    `CHK(pwm_oe, 1'b0)
    `CHK(rdy_oe, 1'b1)
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic close_out;
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run is about 5700 cycles; limit leaves wide margin
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_gate();
    t_start(8'hC8);
    t_track();
    t_faults();
    t_disable();
    t_off_hold();
    // Second start with another offset moves the final target
    offs = 8'h10;
    t_start(8'hC8);
    t_off_run();
    close_out();
  end
endmodule // tb_top
